// ===== core/pss_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer #(
  parameter int unsigned TICK_CYCLES = pss_pkg::DWELL_TICK_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        EXTENDED,
  input  wire logic        ADVANCED,
  input  wire logic [1:0]  AUX_MODE,
  input  wire logic        START_CMD,
  input  wire logic        INDIRECT_START_CMD,
  input  wire logic [6:0]  INDIRECT_STEP,
  input  wire logic        AUX_CODE_OFF_CMD,
  input  wire logic        ERROR_CLEAR,
  input  wire logic        TARGET_REACHED,
  input  wire logic [31:0] CUR_POS,
  input  wire logic        STEP_WR,
  input  wire logic [6:0]  STEP_WR_IDX,
  input  wire logic [1:0]  STEP_WR_PATTERN,
  input  wire logic        STEP_WR_METHOD,
  input  wire logic        STEP_WR_COORD,
  input  wire logic [6:0]  STEP_WR_REPEAT,
  input  wire logic [31:0] STEP_WR_TARGET,
  input  wire logic [15:0] STEP_WR_CODE,
  input  wire logic [1:0]  STEP_WR_RAMP,
  input  wire logic [16:0] STEP_WR_SPEED,
  input  wire logic [15:0] STEP_WR_DWELL,
  output logic             IN_OPERATION,
  output logic             DWELLING,
  output logic             POS_COMPLETE,
  output logic             AUX_CODE_ON,
  output logic      [15:0] AUX_CODE,
  output logic             ERROR,
  output logic      [15:0] ERROR_CODE,
  output logic      [6:0]  CUR_STEP,
  output logic             CMD_LOAD,
  output logic             CMD_STOP,
  output logic      [31:0] CMD_TARGET,
  output logic      [16:0] CMD_SPEED,
  output logic      [1:0]  CMD_RAMP_SEL,
  output logic             CMD_DIR
);
  pss_pkg::pss_state_type state_q;
  pss_pkg::pss_state_type state_d;
  logic [6:0]  run_q;
  logic [1:0]  pat_q;
  logic        method_q;
  logic [6:0]  rstep_q;
  logic [15:0] code_q;
  logic [15:0] dwell_q;
  logic        dir_q;
  logic        aux_q;
  logic [1:0]  rd_pat;
  logic        rd_method;
  logic        rd_coord;
  logic [6:0]  rd_rstep;
  logic [31:0] rd_target;
  logic [15:0] rd_code;
  logic [1:0]  rd_ramp;
  logic [16:0] rd_speed;
  logic [15:0] rd_dwell;
  logic        rd_dir;
  logic [6:0]  start_idx;
  logic [6:0]  nxt;
  logic [6:0]  rd_idx;
  logic        start_req;
  logic        with_mode;
  logic        after_mode;
  logic        dwell_done;
  logic        launch;
  logic        halt;
  logic        fin;
  logic        adv;
  logic        err_set;
  logic [15:0] err_val;
  logic        complete;
  logic        aux_set;
  logic [15:0] aux_val;
  logic        go_dwell;
  logic        go_hold;
  function automatic logic dir_of(input logic coord, input logic [31:0] tgt,
                                  input logic [31:0] pos);
    dir_of = (coord == pss_pkg::COORD_INC) ? tgt[31] : ($signed(tgt) < $signed(pos));
  endfunction
  pss_step_mem u_mem (
    .clk       (CLK),
    .rst_n     (RESETN),
    .wr        (STEP_WR),
    .wr_idx    (STEP_WR_IDX),
    .wr_pat    (STEP_WR_PATTERN),
    .wr_method (STEP_WR_METHOD),
    .wr_coord  (STEP_WR_COORD),
    .wr_rstep  (STEP_WR_REPEAT),
    .wr_target (STEP_WR_TARGET),
    .wr_code   (STEP_WR_CODE),
    .wr_ramp   (STEP_WR_RAMP),
    .wr_speed  (STEP_WR_SPEED),
    .wr_dwell  (STEP_WR_DWELL),
    .rd_idx    (rd_idx),
    .rd_pat    (rd_pat),
    .rd_method (rd_method),
    .rd_coord  (rd_coord),
    .rd_rstep  (rd_rstep),
    .rd_target (rd_target),
    .rd_code   (rd_code),
    .rd_ramp   (rd_ramp),
    .rd_speed  (rd_speed),
    .rd_dwell  (rd_dwell)
  );
  pss_dwell_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_dwell (
    .clk      (CLK),
    .rst_n    (RESETN),
    .load     (go_dwell),
    .dwell_ms (dwell_q),
    .done     (dwell_done)
  );
  always_comb begin
    start_req = START_CMD || INDIRECT_START_CMD;
    start_idx = (INDIRECT_START_CMD && INDIRECT_STEP != 7'h00) ? INDIRECT_STEP
                                                               : CUR_STEP;
    nxt = (method_q == pss_pkg::METHOD_REPEAT) ? rstep_q
                                               : run_q + 7'h01;
    rd_idx = (state_q == pss_pkg::ST_IDLE) ? start_idx : nxt;
    rd_dir = dir_of(rd_coord, rd_target, CUR_POS);
    with_mode  = (AUX_MODE == pss_pkg::AUX_WITH) && ADVANCED;
    after_mode = (AUX_MODE != pss_pkg::AUX_NONE) && !with_mode;
  end
  // sequencing decisions
  always_comb begin
    launch   = 1'b0;
    halt     = 1'b0;
    fin      = 1'b0;
    adv      = 1'b0;
    err_set  = 1'b0;
    err_val  = pss_pkg::ERR_NONE;
    complete = 1'b0;
    aux_set  = 1'b0;
    go_dwell = 1'b0;
    go_hold  = 1'b0;
    unique case (state_q)
      pss_pkg::ST_IDLE: begin
        if (start_req) begin
          if (aux_q) begin
            err_set = 1'b1;
            err_val = pss_pkg::ERR_AUX_PENDING;
          end else if (!pss_pkg::step_ok(rd_idx, EXTENDED)) begin
            err_set = 1'b1;
            err_val = pss_pkg::ERR_STEP_RANGE;
          end else begin
            launch = 1'b1;
          end
        end
      end
      pss_pkg::ST_MOVE: begin
        if (TARGET_REACHED) begin
          if (pat_q == pss_pkg::PAT_CONT) begin
            adv     = 1'b1;
            aux_set = after_mode && code_q != 16'h0;
            if (!pss_pkg::step_ok(nxt, EXTENDED)) begin
              halt = 1'b1;
            end else if (rd_dir != dir_q) begin
              halt    = 1'b1;
              err_set = 1'b1;
              err_val = pss_pkg::ERR_DIR_REVERSE;
            end else begin
              launch = 1'b1;
            end
          end else if (dwell_q == 16'h0) begin
            fin = 1'b1;
          end else begin
            go_dwell = 1'b1;
          end
        end
      end
      pss_pkg::ST_DWELL: begin
        fin = dwell_done;
      end
      pss_pkg::ST_HOLD: begin
        if (!aux_q) begin
          if (pss_pkg::step_ok(nxt, EXTENDED)) begin
            launch = 1'b1;
          end else begin
            halt = 1'b1;
          end
        end
      end
    endcase
    if (fin) begin
      adv     = 1'b1;
      aux_set = after_mode && code_q != 16'h0;
      if (pat_q == pss_pkg::PAT_END) begin
        halt     = 1'b1;
        complete = 1'b1;
      end else if (aux_q || aux_set) begin
        go_hold = 1'b1;
      end else if (pss_pkg::step_ok(nxt, EXTENDED)) begin
        launch = 1'b1;
      end else begin
        halt = 1'b1;
      end
    end
    aux_val = code_q;
    if (launch && with_mode && rd_code != 16'h0) begin
      aux_set = 1'b1;
      aux_val = rd_code;
    end
  end

  always_comb begin
    state_d = state_q;
    if (launch) begin
      state_d = pss_pkg::ST_MOVE;
    end else if (go_dwell) begin
      state_d = pss_pkg::ST_DWELL;
    end else if (go_hold) begin
      state_d = pss_pkg::ST_HOLD;
    end else if (halt) begin
      state_d = pss_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q      <= pss_pkg::ST_IDLE;
      IN_OPERATION <= 1'b0;
      DWELLING     <= 1'b0;
      POS_COMPLETE <= 1'b0;
    end else begin
      state_q      <= state_d;
      IN_OPERATION <= state_d != pss_pkg::ST_IDLE;
      DWELLING     <= state_d == pss_pkg::ST_DWELL;
      POS_COMPLETE <= complete;
    end
  end
  // latched data of the running step and the drive command
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      run_q        <= 7'h00;
      pat_q        <= pss_pkg::PAT_END;
      method_q     <= pss_pkg::METHOD_SINGLE;
      rstep_q      <= 7'h00;
      code_q       <= 16'h0;
      dwell_q      <= 16'h0;
      dir_q        <= 1'b0;
      CMD_TARGET   <= 32'h0;
      CMD_SPEED    <= 17'h0;
      CMD_RAMP_SEL <= 2'h0;
      CMD_DIR      <= 1'b0;
    end else if (launch) begin
      run_q        <= rd_idx;
      pat_q        <= rd_pat;
      method_q     <= rd_method;
      rstep_q      <= rd_rstep;
      code_q       <= rd_code;
      dwell_q      <= rd_dwell;
      dir_q        <= rd_dir;
      CMD_TARGET   <= rd_target;
      CMD_SPEED    <= rd_speed;
      CMD_RAMP_SEL <= rd_ramp;
      CMD_DIR      <= rd_dir;
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CMD_LOAD <= 1'b0;
      CMD_STOP <= 1'b0;
    end else begin
      CMD_LOAD <= launch;
      CMD_STOP <= halt && state_q == pss_pkg::ST_MOVE && !TARGET_REACHED || err_set && !start_req;
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CUR_STEP <= pss_pkg::STEP_RST;
    end else if (launch) begin
      CUR_STEP <= rd_idx;
    end else if (adv) begin
      CUR_STEP <= nxt;
    end
  end
  // set wins over a simultaneous code-off
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      aux_q    <= 1'b0;
      AUX_CODE <= 16'h0;
    end else if (aux_set) begin
      aux_q    <= 1'b1;
      AUX_CODE <= aux_val;
    end else if (AUX_CODE_OFF_CMD) begin
      aux_q <= 1'b0;
    end
  end
  assign AUX_CODE_ON = aux_q;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ERROR      <= 1'b0;
      ERROR_CODE <= pss_pkg::ERR_NONE;
    end else if (err_set) begin
      ERROR      <= 1'b1;
      ERROR_CODE <= err_val;
    end else if (ERROR_CLEAR) begin
      ERROR      <= 1'b0;
      ERROR_CODE <= pss_pkg::ERR_NONE;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence end_reach_s;
    state_q == pss_pkg::ST_MOVE && TARGET_REACHED && pat_q == pss_pkg::PAT_END
      && dwell_q == 16'h0;
  endsequence
  repeat_next_a: assert property (end_reach_s and method_q == pss_pkg::METHOD_REPEAT
    |=> CUR_STEP == $past(rstep_q)) else $error("repeat step not taken");
  single_next_a: assert property (end_reach_s and method_q == pss_pkg::METHOD_SINGLE
    |=> CUR_STEP == $past(run_q) + 7'h01) else $error("single step not advanced");
  indirect_zero_a: assert property (state_q == pss_pkg::ST_IDLE && INDIRECT_STEP == 7'h00
    && INDIRECT_START_CMD && !aux_q && pss_pkg::step_ok(CUR_STEP, EXTENDED)
    |=> CMD_LOAD && run_q == $past(CUR_STEP)) else $error("indirect zero wrong step");
  aux_block_a: assert property (state_q == pss_pkg::ST_IDLE && start_req && aux_q
    |=> !CMD_LOAD && ERROR && ERROR_CODE == pss_pkg::ERR_AUX_PENDING)
    else $error("start with code pending moved");
  end_stop_a: assert property (end_reach_s |=> POS_COMPLETE && !IN_OPERATION
    ##1 !POS_COMPLETE) else $error("end step completion wrong");
  keep_quiet_a: assert property (state_q == pss_pkg::ST_DWELL && pat_q == pss_pkg::PAT_KEEP
    |=> !POS_COMPLETE) else $error("keep step raised completion");
  dwell_busy_a: assert property (DWELLING |-> IN_OPERATION)
    else $error("dwell without operation flag");
  aux_off_a: assert property (AUX_CODE_OFF_CMD && !aux_set |=> !AUX_CODE_ON)
    else $error("code-off ignored");
  dir_rev_a: assert property (state_q == pss_pkg::ST_MOVE && TARGET_REACHED
    && pat_q == pss_pkg::PAT_CONT && pss_pkg::step_ok(nxt, EXTENDED) && rd_dir != dir_q
    |=> ERROR_CODE == pss_pkg::ERR_DIR_REVERSE && !IN_OPERATION) else $error("reversal kept running");
  hold_go_a: assert property (state_q == pss_pkg::ST_HOLD && !aux_q
    && pss_pkg::step_ok(nxt, EXTENDED) |=> CMD_LOAD) else $error("hold did not resume");
endmodule // pss_sequencer
`default_nettype wire

// ===== core/pss_pkg.sv
package pss_pkg;
  localparam int unsigned        CLK_PERIOD_NS   = 20;
  localparam int unsigned        DWELL_TICK_NS   = 1000000;
  localparam int unsigned        DWELL_TICK_CYC  = DWELL_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned        STEP_CNT        = 80;
  localparam logic [6:0]         STEP_MAX_BASIC  = 7'h1e;
  localparam logic [6:0]         STEP_MAX_EXT    = 7'h50;
  localparam logic [6:0]         STEP_RST        = 7'h01;
  localparam logic [1:0]         PAT_END         = 2'h0;
  localparam logic [1:0]         PAT_KEEP        = 2'h1;
  localparam logic [1:0]         PAT_CONT        = 2'h2;
  localparam logic               METHOD_SINGLE   = 1'h0;
  localparam logic               METHOD_REPEAT   = 1'h1;
  localparam logic               COORD_INC       = 1'h1;
  localparam logic [1:0]         AUX_NONE        = 2'h0;
  localparam logic [1:0]         AUX_WITH        = 2'h1;
  localparam logic [1:0]         AUX_AFTER       = 2'h2;
  localparam logic [15:0]        ERR_AUX_PENDING = 16'h00e9;
  localparam logic [15:0]        ERR_DIR_REVERSE = 16'h01ff;
  localparam logic [15:0]        ERR_STEP_RANGE  = 16'h0200;
  localparam logic [15:0]        ERR_NONE        = 16'h0000;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_MOVE  = 4'h2,
    ST_DWELL = 4'h4,
    ST_HOLD  = 4'h8
  } pss_state_type;

  function automatic logic step_ok(input logic [6:0] idx, input logic ext);
    step_ok = (idx != 7'h00) && (idx <= (ext ? STEP_MAX_EXT : STEP_MAX_BASIC));
  endfunction
endpackage

// ===== core/pss_step_mem.sv
`timescale 1ns/1ps
`default_nettype none
module pss_step_mem (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr,
  input  wire logic [6:0]  wr_idx,
  input  wire logic [1:0]  wr_pat,
  input  wire logic        wr_method,
  input  wire logic        wr_coord,
  input  wire logic [6:0]  wr_rstep,
  input  wire logic [31:0] wr_target,
  input  wire logic [15:0] wr_code,
  input  wire logic [1:0]  wr_ramp,
  input  wire logic [16:0] wr_speed,
  input  wire logic [15:0] wr_dwell,
  input  wire logic [6:0]  rd_idx,
  output logic      [1:0]  rd_pat,
  output logic             rd_method,
  output logic             rd_coord,
  output logic      [6:0]  rd_rstep,
  output logic      [31:0] rd_target,
  output logic      [15:0] rd_code,
  output logic      [1:0]  rd_ramp,
  output logic      [16:0] rd_speed,
  output logic      [15:0] rd_dwell
);
  localparam int unsigned W = 94;
  logic [W-1:0] mem_q [1:pss_pkg::STEP_CNT];
  logic [W-1:0] rd_w;

  // step data area, entries indexed 1..80
  genvar g;
  generate
    for (g = 1; g <= pss_pkg::STEP_CNT; g++) begin : g_ent
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_q[g] <= '0;
        end else if (wr && wr_idx == 7'(g)) begin
          mem_q[g] <= {wr_pat, wr_method, wr_coord, wr_rstep, wr_target,
                       wr_code, wr_ramp, wr_speed, wr_dwell};
        end
      end
    end
  endgenerate

  always_comb begin
    rd_w = '0;
    if (rd_idx != 7'h00 && rd_idx <= 7'(pss_pkg::STEP_CNT)) begin
      rd_w = mem_q[rd_idx];
    end
  end

  assign {rd_pat, rd_method, rd_coord, rd_rstep, rd_target,
          rd_code, rd_ramp, rd_speed, rd_dwell} = rd_w;
endmodule // pss_step_mem
`default_nettype wire

// ===== core/pss_dwell_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pss_dwell_timer #(
  parameter int unsigned TICK_CYCLES = pss_pkg::DWELL_TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic [15:0] dwell_ms,
  output logic             done
);
  logic [31:0] pre_q;
  logic [15:0] ms_q;
  logic        run_q;
  logic        tick;

  // prescaler restarts on load so the first millisecond is whole
  assign tick = run_q && (pre_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 32'h0;
    end else if (load || tick) begin
      pre_q <= 32'h0;
    end else if (run_q) begin
      pre_q <= pre_q + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_q  <= 16'h0;
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        ms_q  <= dwell_ms;
        run_q <= dwell_ms != 16'h0;
      end else if (tick) begin
        ms_q <= ms_q - 16'h1;
        if (ms_q == 16'h1) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end
      end
    end
  end
endmodule // pss_dwell_timer
`default_nettype wire

// ===== sim/pss_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module pss_drive_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic        stop,
  input  wire logic [31:0] target,
  input  wire logic [7:0]  lag,
  output logic             reached,
  output logic      [31:0] pos
);
  logic [7:0]  cnt_q;
  logic        busy_q;
  logic [31:0] tgt_q;
  // travel takes lag+1 cycles after the load, then one reach pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= 8'h00;
      busy_q  <= 1'b0;
      tgt_q   <= 32'h0;
      reached <= 1'b0;
      pos     <= 32'h0;
    end else begin
      reached <= 1'b0;
      if (stop) begin
        busy_q <= 1'b0;
      end else if (load) begin
        busy_q <= 1'b1;
        cnt_q  <= lag;
        tgt_q  <= target;
      end else if (busy_q && cnt_q == 8'h00) begin
        busy_q  <= 1'b0;
        reached <= 1'b1;
        pos     <= tgt_q;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule // pss_drive_model
`default_nettype wire

// ===== sim/tb_positioning_step_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_positioning_step_sequencer;
  localparam int TK = 4;
  logic        CLK = 1'b0, RESETN = 1'b0, EXTENDED = 1'b0, ADVANCED = 1'b0;
  logic [1:0]  AUX_MODE = pss_pkg::AUX_AFTER;
  logic        START_CMD = 1'b0, INDIRECT_START_CMD = 1'b0, AUX_CODE_OFF_CMD = 1'b0;
  logic        ERROR_CLEAR = 1'b0, TARGET_REACHED, STEP_WR = 1'b0;
  logic [6:0]  INDIRECT_STEP = 7'h00, STEP_WR_IDX = 7'h00, STEP_WR_REPEAT = 7'h00;
  logic [1:0]  STEP_WR_PATTERN = 2'h0, STEP_WR_RAMP = 2'h0;
  logic        STEP_WR_METHOD = 1'b0, STEP_WR_COORD = 1'b0;
  logic [31:0] CUR_POS, STEP_WR_TARGET = 32'h0;
  logic [15:0] STEP_WR_CODE = 16'h0, STEP_WR_DWELL = 16'h0, AUX_CODE, ERROR_CODE;
  logic [16:0] STEP_WR_SPEED = 17'h0, CMD_SPEED;
  logic        IN_OPERATION, DWELLING, POS_COMPLETE, AUX_CODE_ON, ERROR;
  logic        CMD_LOAD, CMD_STOP, CMD_DIR;
  logic [6:0]  CUR_STEP;
  logic [31:0] CMD_TARGET;
  logic [1:0]  CMD_RAMP_SEL;
  logic [7:0]  lag = 8'h05;
  int          n_errors = 0, num_checks = 0, cyc = 0, t_hit = 0, dt;

  pss_sequencer #(.TICK_CYCLES(TK)) dut (.*);
  pss_drive_model drv (.clk(CLK), .rst_n(RESETN), .load(CMD_LOAD), .stop(CMD_STOP),
    .target(CMD_TARGET), .lag(lag), .reached(TARGET_REACHED), .pos(CUR_POS));

  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (TARGET_REACHED) t_hit <= cyc + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // speed at the top of the legal span, ramp set follows the step number
  task automatic wr(input logic [6:0] i, input logic [1:0] p, input logic m, input logic c,
                    input logic [6:0] r, input logic [31:0] t, input logic [15:0] code,
                    input logic [15:0] dw);
    @(negedge CLK);
    STEP_WR = 1'b1;
    STEP_WR_IDX = i;
    STEP_WR_PATTERN = p;
    STEP_WR_METHOD = m;
    STEP_WR_COORD = c;
    STEP_WR_REPEAT = r;
    STEP_WR_TARGET = t;
    STEP_WR_CODE = code;
    STEP_WR_DWELL = dw;
    STEP_WR_RAMP = i[1:0];
    STEP_WR_SPEED = 17'h186a0;
    @(negedge CLK);
    STEP_WR = 1'b0;
  endtask

  task automatic go(input logic ind, input logic [6:0] s);
    @(negedge CLK);
    START_CMD = !ind;
    INDIRECT_START_CMD = ind;
    INDIRECT_STEP = s;
    @(negedge CLK);
    START_CMD = 1'b0;
    INDIRECT_START_CMD = 1'b0;
  endtask

  task automatic pls(input bit clr);
    @(negedge CLK);
    if (clr) ERROR_CLEAR = 1'b1;
    else AUX_CODE_OFF_CMD = 1'b1;
    @(negedge CLK);
    ERROR_CLEAR = 1'b0;
    AUX_CODE_OFF_CMD = 1'b0;
  endtask

  // 0 load, 1 completion, 2 reach; dt is cycles since the last reach
  task automatic wt(input int w, output int d);
    logic hit;
    d = -1;
    for (int k = 0; k < 400 && d < 0; k++) begin
      @(negedge CLK);
      hit = (w == 0) ? CMD_LOAD : (w == 1) ? POS_COMPLETE : TARGET_REACHED;
      if (hit === 1'b1) d = cyc - t_hit;
    end
    if (d < 0) chk(32'h0, 32'h1, "wait expired");
  endtask

  task automatic t_seq;
    wr(7'h01, pss_pkg::PAT_END, pss_pkg::METHOD_SINGLE, 1'b0, 7'h00, 32'h7fffffff, 16'h0, 16'h0);
    wr(7'h02, pss_pkg::PAT_END, pss_pkg::METHOD_REPEAT, 1'b0, 7'h01, 32'h80000000, 16'h0, 16'h0);
    go(1'b0, 7'h00);
    chk(CMD_LOAD, 1'b1, "load");
    chk(CMD_TARGET, 32'h7fffffff, "target");
    chk(CMD_RAMP_SEL, 2'h1, "ramp");
    chk(CMD_SPEED, 17'h186a0, "speed");
    wt(1, dt);
    chk(dt, 32'h0, "end stop delay");
    chk(CUR_STEP, 7'h02, "next single");
    @(negedge CLK);
    chk(POS_COMPLETE, 1'b0, "one cycle");
    go(1'b0, 7'h00);
    chk(CMD_TARGET, 32'h80000000, "target");
    chk(CMD_RAMP_SEL, 2'h2, "ramp");
    chk(CMD_DIR, 1'b1, "reverse dir");
    wt(1, dt);
    chk(CUR_STEP, 7'h01, "next repeat");
    wr(7'h01, pss_pkg::PAT_END, pss_pkg::METHOD_SINGLE, 1'b0, 7'h00, 32'h12345678, 16'h0, 16'h0);
    go(1'b0, 7'h00);
    chk(CMD_TARGET, 32'h12345678, "rewritten");
    wt(1, dt);
    $display("end t_seq");
  endtask

  task automatic t_keep;
    wr(7'h03, pss_pkg::PAT_KEEP, pss_pkg::METHOD_SINGLE, 1'b0, 7'h00, 32'h64, 16'h0, 16'h2);
    wr(7'h04, pss_pkg::PAT_END, pss_pkg::METHOD_SINGLE, 1'b0, 7'h00, 32'hc8, 16'h0, 16'h1);
    wr(7'h05, pss_pkg::PAT_END, pss_pkg::METHOD_SINGLE, 1'b0, 7'h00, 32'h12c, 16'h0, 16'h0);
    go(1'b1, 7'h03);
    wt(0, dt);
    chk(CMD_TARGET, 32'hc8, "keep chains");
    chk(IN_OPERATION, 1'b1, "keep running");
    wt(2, dt);
    @(negedge CLK);
    @(negedge CLK);
    chk({DWELLING, IN_OPERATION}, 2'h3, "dwell busy");
    wt(1, dt);
    chk(dt, TK + 1, "dwell length");
    chk(IN_OPERATION, 1'b0, "dwell over");
    go(1'b1, 7'h00);
    chk(CMD_TARGET, 32'h12c, "indirect zero");
    wt(1, dt);
    $display("end t_keep");
  endtask

  task automatic t_err;
    wr(7'h06, pss_pkg::PAT_END, pss_pkg::METHOD_REPEAT, 1'b0, 7'h00, 32'h190, 16'h0, 16'h0);
    go(1'b1, 7'h06);
    wt(1, dt);
    chk(CUR_STEP, 7'h00, "repeat zero");
    go(1'b0, 7'h00);
    chk({CMD_LOAD, ERROR}, 2'h1, "refused");
    chk(ERROR_CODE, pss_pkg::ERR_STEP_RANGE, "code");
    pls(1'b1);
    go(1'b1, 7'h1f);
    chk(ERROR_CODE, pss_pkg::ERR_STEP_RANGE, "basic range");
    pls(1'b1);
    EXTENDED = 1'b1;
    wr(7'h1f, pss_pkg::PAT_END, pss_pkg::METHOD_SINGLE, 1'b0, 7'h00, 32'h1f4, 16'h0, 16'h0);
    go(1'b1, 7'h1f);
    chk({CMD_LOAD, ERROR}, 2'h2, "extended range");
    wt(1, dt);
    $display("end t_err");
  endtask

  task automatic t_cont;
    lag = 8'h01;
    wr(7'h07, pss_pkg::PAT_CONT, pss_pkg::METHOD_SINGLE, 1'b1, 7'h00, 32'h64, 16'h7, 16'h0);
    wr(7'h08, pss_pkg::PAT_END, pss_pkg::METHOD_SINGLE, 1'b1, 7'h00, 32'hc8, 16'h0, 16'h0);
    go(1'b1, 7'h07);
    wt(0, dt);
    chk(dt, 32'h0, "no stop");
    chk({IN_OPERATION, POS_COMPLETE}, 2'h2, "still running");
    chk(CMD_TARGET, 32'hc8, "next step");
    chk(CMD_RAMP_SEL, 2'h0, "next ramp");
    chk(AUX_CODE_ON, 1'b1, "code in motion");
    pls(1'b0);
    chk({AUX_CODE_ON, IN_OPERATION}, 2'h1, "off in motion");
    wt(1, dt);
    wr(7'h09, pss_pkg::PAT_CONT, pss_pkg::METHOD_SINGLE, 1'b1, 7'h00, 32'h64, 16'h0, 16'h0);
    wr(7'h0a, pss_pkg::PAT_END, pss_pkg::METHOD_SINGLE, 1'b1, 7'h00, 32'hffffffce, 16'h0, 16'h0);
    go(1'b1, 7'h09);
    wt(2, dt);
    @(negedge CLK);
    chk({CMD_STOP, IN_OPERATION}, 2'h2, "reversal stop");
    chk(ERROR_CODE, pss_pkg::ERR_DIR_REVERSE, "reversal code");
    pls(1'b1);
    lag = 8'h05;
    $display("end t_cont");
  endtask

  task automatic t_aux;
    wr(7'h0b, pss_pkg::PAT_END, pss_pkg::METHOD_SINGLE, 1'b0, 7'h00, 32'h1f4, 16'hffff, 16'h0);
    wr(7'h0c, pss_pkg::PAT_KEEP, pss_pkg::METHOD_SINGLE, 1'b0, 7'h00, 32'h258, 16'h1, 16'h1);
    wr(7'h0d, pss_pkg::PAT_END, pss_pkg::METHOD_SINGLE, 1'b0, 7'h00, 32'h2bc, 16'h0, 16'h0);
    wr(7'h0e, pss_pkg::PAT_END, pss_pkg::METHOD_SINGLE, 1'b0, 7'h00, 32'h320, 16'h5, 16'h0);
    go(1'b1, 7'h0b);
    wt(1, dt);
    @(negedge CLK);
    chk({AUX_CODE_ON, AUX_CODE}, {1'b1, 16'hffff}, "after code");
    go(1'b0, 7'h00);
    chk({CMD_LOAD, IN_OPERATION}, 2'h0, "held stopped");
    chk(ERROR_CODE, pss_pkg::ERR_AUX_PENDING, "code pending");
    pls(1'b1);
    pls(1'b0);
    chk(AUX_CODE_ON, 1'b0, "code off");
    go(1'b0, 7'h00);
    chk(CMD_TARGET, 32'h258, "restart");
    wt(2, dt);
    repeat (3 * TK) @(negedge CLK);
    chk({IN_OPERATION, AUX_CODE_ON}, 2'h3, "keep standby");
    chk(CMD_TARGET, 32'h258, "no chaining yet");
    pls(1'b0);
    wt(0, dt);
    chk(CMD_TARGET, 32'h2bc, "resumed");
    wt(1, dt);
    @(negedge CLK);
    chk(AUX_CODE_ON, 1'b0, "zero code");
    AUX_MODE = pss_pkg::AUX_NONE;
    go(1'b0, 7'h00);
    wt(1, dt);
    @(negedge CLK);
    chk(AUX_CODE_ON, 1'b0, "mode none");
    AUX_MODE = pss_pkg::AUX_WITH;
    ADVANCED = 1'b1;
    go(1'b1, 7'h0e);
    @(negedge CLK);
    chk({AUX_CODE_ON, AUX_CODE}, {1'b1, 16'h5}, "with mode");
    wt(1, dt);
    $display("end t_aux");
  endtask

  initial begin
    #(20 * 20000);
    n_errors++;
    test_done();
  end

  initial begin
    repeat (10) @(negedge CLK);
    RESETN = 1'b1;
    chk({CUR_STEP, IN_OPERATION}, {7'h01, 1'b0}, "reset state");
    t_seq();
    t_keep();
    t_err();
    t_cont();
    t_aux();
    test_done();
  end
endmodule // tb_positioning_step_sequencer
`default_nettype wire
